/* rtl/tpp_cfg.svh */
// Constants for the 16-bit timer with prescaler, interval and pulse-generator modes.
// Assumes word-wide register access, with byte address equal to four times the index.
`ifndef TPP_CFG_SVH
`define TPP_CFG_SVH

// Register indices; the byte address on the bus is four times the index.
`define TPP_IDX_PORT0_DIRECTION 16'hFF20
`define TPP_IDX_PORT0_LATCH 16'hFF00
`define TPP_IDX_PRESCALE 16'hFFBB
`define TPP_IDX_MODE_CONTROL 16'hFFB0
`define TPP_IDX_CYCLE_COMPARE 16'hFFB2
`define TPP_IDX_WIDTH_COMPARE 16'hFFB4
`define TPP_IDX_OUTPUT_CONTROL 16'hFFB6
`define TPP_IDX_MAIN_COUNTER 16'hFFB8
`define TPP_IDX_STATUS 16'hFFBA

// Reset values.
`define TPP_RST_PRESCALE 8'h00
`define TPP_RST_DIRECTION 4'hF
`define TPP_RST_LATCH 4'h0
`define TPP_RST_COMPARE 16'h0000

// Fixed upper bits of the direction register and reserved prescaler bits.
`define TPP_DIR_FIXED_HI 4'hF
`define TPP_PRM_RSVD_MASK 8'hF3

// Field positions in the prescaler register.
`define TPP_PRM_CLK_LO 0
`define TPP_PRM_CLK_HI 1
`define TPP_PRM_ES0_LO 4
`define TPP_PRM_ES0_HI 5
`define TPP_PRM_ES1_LO 6
`define TPP_PRM_ES1_HI 7

// Shared pin position within port 0, status bit positions.
`define TPP_SHARED_PIN 1
`define TPP_STAT_MATCH 0
`define TPP_STAT_OVF 1
`define TPP_STAT_OUT 2

// Count clock selections and the prescaler wrap points.
`define TPP_CLK_UNDIV 2'h0
`define TPP_CLK_DIV4 2'h1
`define TPP_CLK_DIV256 2'h2
`define TPP_CLK_EXT 2'h3
`define TPP_DIV4_LAST 8'h03
`define TPP_DIV256_LAST 8'hFF
`define TPP_COUNT_MAX 16'hFFFF

`endif

/* rtl/tpp_pkg.sv */
// Types for the 16-bit timer with prescaler, interval and pulse-generator modes.
// Assumes the constants header is included by the design file.
package tpp_pkg;

    // Operating modes written through the mode control register.
    typedef enum logic [1:0] {
        TPP_STOP,
        TPP_INTERVAL,
        TPP_PULSE_GEN,
        TPP_RESERVED
    } tpp_mode_t;

    // Whole state of the timer block.
    typedef struct packed {
        logic [7:0] prm;
        logic [3:0] dir;
        logic [3:0] latch;
        tpp_mode_t mode;
        logic [15:0] cyc;
        logic [15:0] wid;
        logic toe;
        logic [15:0] cnt;
        logic [7:0] div;
        logic ovf;
        logic mflag;
        logic ff;
        logic prev0;
        logic prev1;
        logic armed;
        logic ack;
        logic [31:0] rdata;
        logic edge0;
        logic edge1;
        logic match;
    } tpp_state_t;

endpackage : tpp_pkg

/* rtl/tpp_timer.sv */
// 16-bit timer with prescaler and edge selection, port 0 direction control,
// interval mode and pulse-generator mode, reached over Avalon-MM with waitrequest.
// Assumes capture inputs and port pins are already synchronous to clk_i.
`include "tpp_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module tpp_timer #(
    parameter int ADDR_W = 18
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic capin0_i,
    input wire logic [3:0] port0_i,
    output logic [3:0] port0_o,
    output logic [3:0] port0_oe_o,
    output logic capin0_edge_o,
    output logic capin1_edge_o,
    output logic cycle_match_irq_o,
    output logic timer_output_pin_o
);
    import tpp_pkg::*;

    localparam int IDX_W = ADDR_W - 2;

    // Valid edge test shared by both capture inputs; the prohibited code detects nothing.
    // Staying silent on that code keeps a bad write from producing stray captures.
    function automatic logic edge_hit(input logic [1:0] es, input logic prev, input logic cur);
        logic hit;
        hit = 1'b0;
        case (es)
            2'h0: hit = prev & ~cur;
            2'h1: hit = ~prev & cur;
            2'h3: hit = prev ^ cur;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction : edge_hit

    // Merges one 8-bit field from write data under a byte enable.
    function automatic logic [7:0] merge8(input logic [7:0] old, input logic [7:0] wd,
                                          input logic be);
        return be ? wd : old;
    endfunction : merge8

    // Registered state and its next value; every flop of the block lives in q.
    tpp_state_t q;
    tpp_state_t d;

    // Decoded bus request, run state, count tick and the values shared between processes.
    logic [IDX_W-1:0] idx;
    logic access;
    logic take;
    logic running;
    logic cap1_in;
    logic tick;
    logic [15:0] cyc_w;
    logic [15:0] wid_w;
    logic [31:0] rd_val;
    logic ovf_set;

    assign idx = avs_address_i[ADDR_W-1:2];
    assign access = avs_read_i | avs_write_i;
    // The request is held one cycle, so every access completes on the second edge.
    assign take = access & q.ack;
    assign running = (q.mode == TPP_INTERVAL) || (q.mode == TPP_PULSE_GEN);
    // The shared pin feeds the second capture input only in input mode.
    assign cap1_in = q.dir[`TPP_SHARED_PIN] & port0_i[`TPP_SHARED_PIN];

    // Read mux; unmapped addresses read as zero.
    // Reads have no side effects, so a read may be repeated freely.
    always_comb begin
        rd_val = 32'h0000_0000;
        case (idx)
            IDX_W'(`TPP_IDX_PORT0_DIRECTION): rd_val = {24'h000000, `TPP_DIR_FIXED_HI, q.dir};
            IDX_W'(`TPP_IDX_PORT0_LATCH): rd_val = {28'h0000000, q.latch};
            IDX_W'(`TPP_IDX_PRESCALE): rd_val = {24'h000000, q.prm & `TPP_PRM_RSVD_MASK};
            IDX_W'(`TPP_IDX_MODE_CONTROL): rd_val = {30'h00000000, q.mode};
            IDX_W'(`TPP_IDX_CYCLE_COMPARE): rd_val = {16'h0000, q.cyc};
            IDX_W'(`TPP_IDX_WIDTH_COMPARE): rd_val = {16'h0000, q.wid};
            IDX_W'(`TPP_IDX_OUTPUT_CONTROL): rd_val = {31'h00000000, q.toe};
            IDX_W'(`TPP_IDX_MAIN_COUNTER): rd_val = {16'h0000, q.cnt};
            IDX_W'(`TPP_IDX_STATUS): rd_val = {29'h00000000, q.ff, q.ovf, q.mflag};
            default: rd_val = 32'h0000_0000;
        endcase
    end

    // Count clock selection from the prescaler register.
    // Both divided clocks tap one divider; changing the selection while counting
    // would give one short period, which is why software stops the timer first.
    always_comb begin
        tick = 1'b0;
        case (q.prm[`TPP_PRM_CLK_HI:`TPP_PRM_CLK_LO])
            `TPP_CLK_UNDIV: tick = 1'b1;
            `TPP_CLK_DIV4: tick = (q.div[1:0] == 2'(`TPP_DIV4_LAST));
            `TPP_CLK_DIV256: tick = (q.div == `TPP_DIV256_LAST);
            `TPP_CLK_EXT: tick = q.edge0;
            default: tick = 1'b0;
        endcase
    end

    // Compare values. Software rewrites them only while the timer is stopped, so the
    // registered copies serve and no write bypass is needed.
    assign cyc_w = q.cyc;
    assign wid_w = q.wid;

    // Overflow event of this cycle, kept apart so that a clear in the same cycle
    // cannot hide it.
    assign ovf_set = running & tick & (q.cnt == cyc_w) & (q.mode == TPP_INTERVAL)
                     & (cyc_w == `TPP_COUNT_MAX);

    // Next-state logic for the whole block.
    always_comb begin
        d = q;
        d.ack = access & ~q.ack;
        d.match = 1'b0;
        d.edge0 = 1'b0;
        d.edge1 = 1'b0;
        if (access & ~q.ack) begin
            d.rdata = rd_val;
        end

        // Free-running prescaler; it only runs while the timer counts.
        // Holding it at zero while stopped gives every start the same phase.
        d.div = running ? q.div + 8'h01 : 8'h00;

        // Edge detection. Before the first start the previous sample stays low, so a
        // pulled-up input shows one rising edge on start; afterwards it tracks the pin
        // even while stopped, so a restart sees no spurious edge.
        if (running) begin
            d.armed = 1'b1;
            d.edge0 = edge_hit(q.prm[`TPP_PRM_ES0_HI:`TPP_PRM_ES0_LO], q.prev0, capin0_i);
            d.edge1 = edge_hit(q.prm[`TPP_PRM_ES1_HI:`TPP_PRM_ES1_LO], q.prev1, cap1_in);
            d.prev0 = capin0_i;
            d.prev1 = cap1_in;
        end else if (q.armed) begin
            d.prev0 = capin0_i;
            d.prev1 = cap1_in;
        end

        // Counter, compare and output flip-flop.
        // The counter is held at zero while stopped, so every start counts from zero.
        if (!running) begin
            d.cnt = 16'h0000;
        end else if (tick) begin
            if (q.cnt == cyc_w) begin
                d.cnt = 16'h0000;
                d.match = 1'b1;
                if (ovf_set) begin
                    d.ovf = 1'b1;
                end
                if (q.mode == TPP_PULSE_GEN) begin
                    d.ff = 1'b1;
                end
            end else begin
                d.cnt = q.cnt + 16'h0001;
                if (q.mode == TPP_PULSE_GEN && q.cnt == wid_w) begin
                    d.ff = 1'b0;
                end
            end
        end
        if (d.match) begin
            d.mflag = 1'b1;
        end

        // Register writes; a flag set in the same cycle as its clear stays set.
        // Lanes whose byte enable is low keep their old contents.
        if (take && avs_write_i) begin
            case (idx)
                IDX_W'(`TPP_IDX_PORT0_DIRECTION): begin
                    if (avs_byteenable_i[0]) begin
                        d.dir = avs_writedata_i[3:0];
                    end
                end
                IDX_W'(`TPP_IDX_PORT0_LATCH): begin
                    if (avs_byteenable_i[0]) begin
                        d.latch = avs_writedata_i[3:0];
                    end
                end
                IDX_W'(`TPP_IDX_PRESCALE): begin
                    d.prm = merge8(q.prm, avs_writedata_i[7:0], avs_byteenable_i[0])
                            & `TPP_PRM_RSVD_MASK;
                end
                IDX_W'(`TPP_IDX_MODE_CONTROL): begin
                    if (avs_byteenable_i[0]) begin
                        d.mode = tpp_mode_t'(avs_writedata_i[1:0]);
                        // Pulse output begins high at count zero.
                        // Code 3 is treated as stopped, so it never counts.
                        d.ff = (tpp_mode_t'(avs_writedata_i[1:0]) == TPP_PULSE_GEN);
                    end
                end
                IDX_W'(`TPP_IDX_CYCLE_COMPARE): begin
                    d.cyc = {merge8(q.cyc[15:8], avs_writedata_i[15:8], avs_byteenable_i[1]),
                             merge8(q.cyc[7:0], avs_writedata_i[7:0], avs_byteenable_i[0])};
                end
                IDX_W'(`TPP_IDX_WIDTH_COMPARE): begin
                    d.wid = {merge8(q.wid[15:8], avs_writedata_i[15:8], avs_byteenable_i[1]),
                             merge8(q.wid[7:0], avs_writedata_i[7:0], avs_byteenable_i[0])};
                end
                IDX_W'(`TPP_IDX_OUTPUT_CONTROL): begin
                    if (avs_byteenable_i[0]) begin
                        d.toe = avs_writedata_i[0];
                    end
                end
                IDX_W'(`TPP_IDX_STATUS): begin
                    if (avs_byteenable_i[0]) begin
                        // Writing one clears a flag, but an event in the same cycle wins.
                        d.mflag = (q.mflag & ~avs_writedata_i[`TPP_STAT_MATCH]) | d.match;
                        d.ovf = (q.ovf & ~avs_writedata_i[`TPP_STAT_OVF]) | ovf_set;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // State register with synchronous reset.
    // The reset branch loads constants only, so every flop has a plain reset value.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            q.prm <= `TPP_RST_PRESCALE;
            q.dir <= `TPP_RST_DIRECTION;
            q.latch <= `TPP_RST_LATCH;
            q.mode <= TPP_STOP;
            q.cyc <= `TPP_RST_COMPARE;
            q.wid <= `TPP_RST_COMPARE;
            q.toe <= 1'b0;
            q.cnt <= 16'h0000;
            q.div <= 8'h00;
            q.ovf <= 1'b0;
            q.mflag <= 1'b0;
            q.ff <= 1'b0;
            q.prev0 <= 1'b0;
            q.prev1 <= 1'b0;
            q.armed <= 1'b0;
            q.ack <= 1'b0;
            q.rdata <= 32'h0000_0000;
            q.edge0 <= 1'b0;
            q.edge1 <= 1'b0;
            q.match <= 1'b0;
        end else begin
            q <= d;
        end
    end

    // Bus answer: one wait cycle, read data registered.
    // A request still held after its answer is answered again after one more wait cycle; the master drops it at the answering edge.
    assign avs_waitrequest_o = access & ~q.ack;
    assign avs_readdata_o = q.rdata;

    // Pin drive. The shared pin carries the latch ORed with the gated timer output,
    // so software clears the latch to let the timer output through.
    assign timer_output_pin_o = q.ff & q.toe;
    // Only the shared pin mixes in the timer output; the others are plain latch outputs.
    generate
        for (genvar n = 0; n < 4; n++) begin : g_pin
            if (n == `TPP_SHARED_PIN) begin : g_shared
                assign port0_o[n] = q.latch[n] | (q.ff & q.toe);
            end else begin : g_plain
                assign port0_o[n] = q.latch[n];
            end
            assign port0_oe_o[n] = ~q.dir[n];
        end
    endgenerate

    // Event pulses for the capture and compare logic that sits outside this block.
    assign capin0_edge_o = q.edge0;
    assign capin1_edge_o = q.edge1;
    assign cycle_match_irq_o = q.match;
endmodule : tpp_timer

`default_nettype wire

/* testbench/tb.sv */
// Self-checking bench for the timer: registers, edges, interval and pulse modes.
// Assumes the design and the source model compile alongside it.
`include "tpp_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [17:0] avs_address_i = 18'h0;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [3:0] avs_byteenable_i = 4'hF;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o;
    logic capin0_i;
    logic [3:0] port0_i;
    logic [3:0] port0_o;
    logic [3:0] port0_oe_o;
    logic capin0_edge_o;
    logic capin1_edge_o;
    logic cycle_match_irq_o;
    logic timer_output_pin_o;
    logic run = 1'b0;
    int miscompares = 0;
    int cmp_count = 0;
    int edges = 0;
    int ticks = 0;
    logic [31:0] expq[$];
    tpp_timer #(.ADDR_W(18)) DUT (.clk_i(clk_i), .reset_i(reset_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .capin0_i(capin0_i), .port0_i(port0_i),
        .port0_o(port0_o), .port0_oe_o(port0_oe_o), .capin0_edge_o(capin0_edge_o),
        .capin1_edge_o(capin1_edge_o), .cycle_match_irq_o(cycle_match_irq_o),
        .timer_output_pin_o(timer_output_pin_o));
    tpp_ext_src u_src (.clk_i(clk_i), .rst_i(reset_i), .run_i(run), .lvl0_i(1'b1), .lvl1_i(1'b1),
        .port0_o(port0_o), .port0_oe_o(port0_oe_o), .capin0_o(capin0_i), .pins_o(port0_i));
    // Free-running 50 MHz clock.
    initial begin
        forever #10 clk_i = ~clk_i;
    end
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr
    task automatic complete_run;
        if (miscompares == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run
    task automatic chk(input logic [31:0] exp, input logic [31:0] got, input string what);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Holds the request until waitrequest is seen low at a rising edge, then drops it.
    task automatic bus(input logic wr, input logic [15:0] idx, input logic [31:0] d, input logic [3:0] be);
        @(posedge clk_i);
        avs_address_i <= {idx, 2'b00};
        avs_read_i <= !wr;
        avs_write_i <= wr;
        avs_writedata_i <= d;
        avs_byteenable_i <= be;
        do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
    endtask : bus
    task automatic wr(input logic [15:0] idx, input logic [31:0] d);
        bus(1'b1, idx, d, 4'hF);
    endtask : wr
    task automatic rd(input logic [15:0] idx, input logic [31:0] exp);
        expq.push_back(exp);
        bus(1'b0, idx, 32'h0, 4'hF);
    endtask : rd
    task automatic wait_irq(output int n);
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (cycle_match_irq_o !== 1'b1 && n < 2000);
    endtask : wait_irq
    // Counts high cycles of the timer output and of the shared pin as seen outside.
    task automatic high_count(output int n, output int p);
        n = 0;
        p = 0;
        repeat (12) begin
            @(posedge clk_i);
            n += int'(timer_output_pin_o === 1'b1);
            p += int'(port0_i[1] === 1'b1);
        end
    endtask : high_count
    // Read data meet their noted expectation; edge pulses are tallied; a hang is cut short.
    always @(posedge clk_i) begin
        if (avs_read_i && avs_waitrequest_o === 1'b0) chk(expq.pop_front(), avs_readdata_o, "readdata");
        edges = edges + int'(capin0_edge_o === 1'b1) + int'(capin1_edge_o === 1'b1);
        ticks++;
        if (ticks == 90000) begin
            miscompares++;
            complete_run();
        end
    end
    // Main sequence; every reprogramming except the final output-control write happens with the timer stopped.
    initial begin
        logic [7:0] rnd;
        logic [7:0] v;
        logic [15:0] cyc_t [4];
        int per_t [4];
        int n;
        int p;
        int e;
        rnd = 8'h56;
        cyc_t = '{16'h0004, 16'h0003, 16'h0001, 16'h0002};
        per_t = '{5, 16, 512, 24};
        repeat (16) @(posedge clk_i);
        reset_i <= 1'b0;
        rd(`TPP_IDX_PORT0_DIRECTION, 32'hFF);
        rd(`TPP_IDX_PRESCALE, 32'h0);
        rd(16'hFF40, 32'h0);
        for (int i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            v = rnd | {1'b0, rnd[7], 1'b0, rnd[5], 4'h0};
            wr(`TPP_IDX_PRESCALE, {24'h0, v});
            bus(1'b1, `TPP_IDX_PRESCALE, 32'h0, 4'hE);
            rd(`TPP_IDX_PRESCALE, {24'h0, v & `TPP_PRM_RSVD_MASK});
            wr(`TPP_IDX_PORT0_DIRECTION, {28'h0, rnd[3:0]});
            @(posedge clk_i);
            chk({28'h0, ~rnd[3:0]}, {28'h0, port0_oe_o}, "pin enables");
            rd(`TPP_IDX_PORT0_DIRECTION, {24'h0, 4'hF, rnd[3:0]});
        end
        wr(`TPP_IDX_PORT0_DIRECTION, 32'hF);
        wr(`TPP_IDX_CYCLE_COMPARE, 32'h10);
        wr(`TPP_IDX_PRESCALE, 32'hD0);
        e = edges;
        wr(`TPP_IDX_MODE_CONTROL, 32'h1);
        repeat (4) @(posedge clk_i);
        chk(e + 2, edges, "edges at first start");
        wr(`TPP_IDX_MODE_CONTROL, 32'h3);
        e = edges;
        wr(`TPP_IDX_MODE_CONTROL, 32'h1);
        repeat (4) @(posedge clk_i);
        chk(e, edges, "edges at restart");
        for (int i = 0; i < 4; i++) begin
            wr(`TPP_IDX_MODE_CONTROL, 32'h0);
            wr(`TPP_IDX_STATUS, 32'h3);
            wr(`TPP_IDX_CYCLE_COMPARE, {16'h0, cyc_t[i]});
            wr(`TPP_IDX_PRESCALE, {30'h0, i[1:0]});
            run <= (i == 3);
            wr(`TPP_IDX_MODE_CONTROL, 32'h1);
            wait_irq(n);
            wait_irq(n);
            chk(per_t[i], n, "interval period");
            rd(`TPP_IDX_STATUS, 32'h1);
        end
        wr(`TPP_IDX_MODE_CONTROL, 32'h0);
        run <= 1'b0;
        // Full-range interval: the match after 65536 ticks must also raise overflow.
        wr(`TPP_IDX_STATUS, 32'h3);
        wr(`TPP_IDX_CYCLE_COMPARE, 32'hFFFF);
        wr(`TPP_IDX_PRESCALE, 32'h0);
        wr(`TPP_IDX_MODE_CONTROL, 32'h1);
        repeat (65540) @(posedge clk_i);
        rd(`TPP_IDX_STATUS, 32'h3);
        wr(`TPP_IDX_MODE_CONTROL, 32'h0);
        wr(`TPP_IDX_PORT0_DIRECTION, 32'hD);
        wr(`TPP_IDX_PORT0_LATCH, 32'h0);
        wr(`TPP_IDX_CYCLE_COMPARE, 32'h5);
        wr(`TPP_IDX_WIDTH_COMPARE, 32'h2);
        wr(`TPP_IDX_OUTPUT_CONTROL, 32'h1);
        wr(`TPP_IDX_PRESCALE, 32'h0);
        wr(`TPP_IDX_MODE_CONTROL, 32'h2);
        wait_irq(n);
        wait_irq(n);
        chk(6, n, "pulse period");
        high_count(n, p);
        chk(6, n, "pulse high cycles");
        chk(6, p, "shared pin high cycles");
        wr(`TPP_IDX_OUTPUT_CONTROL, 32'h0);
        high_count(n, p);
        chk(0, n, "disabled output high cycles");
        chk(0, p, "disabled shared pin high cycles");
        complete_run();
    end
endmodule : tb
`default_nettype wire

/* testbench/tpp_ext_src.sv */
// Signal sources outside the timer: capture inputs and the port 0 pins.
// Assumes the bench sets the levels and the run request just after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module tpp_ext_src (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic run_i,
    input wire logic lvl0_i,
    input wire logic lvl1_i,
    input wire logic [3:0] port0_o,
    input wire logic [3:0] port0_oe_o,
    output logic capin0_o,
    output logic [3:0] pins_o
);
    logic [2:0] ph_q;
    // Eight-clock square wave, high for four, so each count pulse is long enough.
    always_ff @(posedge clk_i) ph_q <= (rst_i || !run_i) ? 3'h0 : ph_q + 3'h1;
    assign capin0_o = run_i ? ph_q[2] : lvl0_i;
    // A pin shows the timer's value only while its driver is on; idle pins are pulled up, except pin 1, which follows lvl1_i.
    always_comb begin
        for (int n = 0; n < 4; n++) begin
            pins_o[n] = port0_oe_o[n] ? port0_o[n] : (n == 1 ? lvl1_i : 1'b1);
        end
    end
endmodule : tpp_ext_src
`default_nettype wire

/* testbench/tpp_timer_props.sv */
// Concurrent checks on the timer: bus handshake, pin enables, reads, periods, edges.
// Assumes it is bound to tpp_timer and sees only that module's ports.
`include "tpp_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module tpp_timer_props #(
    parameter int ADDR_W = 18
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic capin0_i,
    input wire logic [3:0] port0_i,
    input wire logic [3:0] port0_o,
    input wire logic [3:0] port0_oe_o,
    input wire logic capin0_edge_o,
    input wire logic capin1_edge_o,
    input wire logic cycle_match_irq_o,
    input wire logic timer_output_pin_o
);
    logic [15:0] idx;
    logic wr_ok;
    logic rd_ok;
    logic [7:0] prm_q;
    logic [15:0] cyc_q;
    logic dir1_q;
    logic ok_q;
    logic [31:0] gap_q;
    logic [31:0] per_m1;
    // Completed accesses; the expected gap assumes an internal count clock.
    assign idx = 16'(avs_address_i[ADDR_W-1:2]);
    assign wr_ok = avs_write_i && !avs_waitrequest_o;
    assign rd_ok = avs_read_i && !avs_waitrequest_o;
    assign per_m1 = (({16'h0000, cyc_q} + 32'h1) << (prm_q[1] ? 8 : (prm_q[0] ? 2 : 0))) - 32'h1;
    // Shadow registers; a write drops the period check so a restart is never judged.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            prm_q <= 8'h00;
            cyc_q <= 16'h0000;
            dir1_q <= 1'b1;
            ok_q <= 1'b0;
            gap_q <= 32'h0;
        end else begin
            gap_q <= cycle_match_irq_o ? 32'h0 : gap_q + 32'h1;
            ok_q <= wr_ok ? 1'b0 : (ok_q || cycle_match_irq_o);
            if (wr_ok && avs_byteenable_i[0]) begin
                if (idx == `TPP_IDX_PRESCALE) prm_q <= avs_writedata_i[7:0];
                if (idx == `TPP_IDX_PORT0_DIRECTION) dir1_q <= avs_writedata_i[1];
                if (idx == `TPP_IDX_CYCLE_COMPARE) cyc_q <= avs_writedata_i[15:0];
            end
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    sequence req_start;
        (avs_read_i || avs_write_i) && !$past(avs_read_i || avs_write_i);
    endsequence
    sequence ack_next;
        avs_waitrequest_o ##1 !avs_waitrequest_o;
    endsequence
    bus_wait_a: assert property (req_start |-> ack_next)
        else $error("waitrequest timing wrong");
    dir_reset_a: assert property ($fell(reset_i) |-> port0_oe_o == 4'h0)
        else $error("pin drivers on after reset");
    dir_oe_a: assert property (
        wr_ok && avs_byteenable_i[0] && idx == `TPP_IDX_PORT0_DIRECTION
        |=> port0_oe_o == ~$past(avs_writedata_i[3:0])) else $error("pin enable wrong");
    dir_read_a: assert property (
        rd_ok && idx == `TPP_IDX_PORT0_DIRECTION |-> avs_readdata_o[7:4] == 4'hF)
        else $error("direction upper bits wrong");
    prm_read_a: assert property (
        rd_ok && idx == `TPP_IDX_PRESCALE |-> avs_readdata_o[3:2] == 2'h0)
        else $error("prescaler reserved bits wrong");
    out_off_a: assert property (
        wr_ok && avs_byteenable_i[0] && idx == `TPP_IDX_OUTPUT_CONTROL && !avs_writedata_i[0]
        |=> !timer_output_pin_o) else $error("output not forced low");
    irq_period_a: assert property (
        cycle_match_irq_o && ok_q && prm_q[1:0] != 2'h3 |-> gap_q == per_m1)
        else $error("match period wrong");
    irq_pulse_a: assert property (cycle_match_irq_o |=> !cycle_match_irq_o)
        else $error("match pulse too long");
    edge0_sel_a: assert property (
        capin0_edge_o && prm_q[5:4] != 2'h3 |-> $past(capin0_i) == prm_q[4])
        else $error("first capture edge wrong");
    edge1_sel_a: assert property (
        capin1_edge_o && dir1_q && prm_q[7:6] != 2'h3 |-> $past(port0_i[1]) == prm_q[6])
        else $error("second capture edge wrong");
endmodule : tpp_timer_props
bind tpp_timer tpp_timer_props #(.ADDR_W(ADDR_W)) u_props (.clk_i(clk_i), .reset_i(reset_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .capin0_i(capin0_i), .port0_i(port0_i), .port0_o(port0_o), .port0_oe_o(port0_oe_o),
    .capin0_edge_o(capin0_edge_o), .capin1_edge_o(capin1_edge_o),
    .cycle_match_irq_o(cycle_match_irq_o), .timer_output_pin_o(timer_output_pin_o));
`default_nettype wire
